// ### sgps_supervisor.sv
// switchgear position supervisor with apb registers
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - position is a 2-bit code (0 indeterminate, 1 open, 2 closed, 3 disturbed) plus flags.
// - a close command starts the closing travel timer and shows indeterminate meanwhile.
// - closed feedback before the closing timer ends gives the closed state.
// - a travel timeout without the new position gives disturbed instead of indeterminate.
// - an open command runs the opening timer the same way, ending open or disturbed.
// - with two contacts, closed=1/open=0 means closed and the reverse means open.
// - with two equal contacts, indeterminate while a timer runs, disturbed otherwise.
// - each command pulse lasts at most its travel time and ends early on new position.
// - with a single contact configured the one-contact flag is set.
// - with one contact only the direction that contact reports is supervised.
// - with one contact, timely arrival sets position and success and drops indeterminate.
// - with one contact a timeout starts the optional dwell, then the end position is assumed.
// - closed contact only: 1 is closed, 0 is indeterminate while closing, else open.
// - open contact only: 1 is open, 0 is indeterminate while opening, else closed.
// - with no contact input assigned the code is disturbed.
module sgps_supervisor #(
	parameter int CNT_W = 24
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic aux_closed_pin,
	input wire logic aux_open_pin,
	output logic close_cmd,
	output logic open_cmd,
	output logic [1:0] pos_code,
	output sgps_pkg::sgps_flags_t flags,
	output logic one_contact_flag,
	output logic command_success_flag,
	output logic irq
);
	initial begin
		if (CNT_W < 2 || CNT_W > 32) $error("sgps_supervisor: CNT_W out of range");
	end

	// contact synchronisers, three stages each
	logic [2:0] csync_reg;
	logic [2:0] osync_reg;
	logic closed_s;
	logic open_s;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			csync_reg <= 3'h0;
			osync_reg <= 3'h0;
			closed_s <= 1'b0;
			open_s <= 1'b0;
		end else begin
			csync_reg <= {csync_reg[1:0], aux_closed_pin};
			osync_reg <= {osync_reg[1:0], aux_open_pin};
			// a change only counts once stages two and three agree
			if (csync_reg[1] == csync_reg[2]) closed_s <= csync_reg[2];
			if (osync_reg[1] == osync_reg[2]) open_s <= osync_reg[2];
		end
	end

	// registers
	sgps_pkg::sgps_cfg_t cfg_reg;
	logic [CNT_W-1:0] ton_reg;
	logic [CNT_W-1:0] toff_reg;
	logic [CNT_W-1:0] tdwell_reg;
	logic [sgps_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [sgps_pkg::IRQ_W-1:0] irq_mask_reg;

	// apb decode
	wire apb_setup = psel && !penable;
	wire apb_access = psel && penable && pready;
	wire hit_ctrl = paddr == sgps_pkg::ADDR_CTRL;
	wire hit_cmd = paddr == sgps_pkg::ADDR_CMD;
	wire hit_ton = paddr == sgps_pkg::ADDR_TMOVE_ON;
	wire hit_toff = paddr == sgps_pkg::ADDR_TMOVE_OFF;
	wire hit_tdwell = paddr == sgps_pkg::ADDR_TDWELL;
	wire hit_status = paddr == sgps_pkg::ADDR_STATUS;
	wire hit_istat = paddr == sgps_pkg::ADDR_IRQ_STAT;
	wire hit_imask = paddr == sgps_pkg::ADDR_IRQ_MASK;
	wire addr_hit = hit_ctrl | hit_cmd | hit_ton | hit_toff | hit_tdwell | hit_status
		| hit_istat | hit_imask;
	wire wr_ok = apb_access && pwrite && !pslverr;
	wire cmd_wr = wr_ok && hit_cmd;
	// only bits already returned are cleared, so a late event survives
	wire [sgps_pkg::IRQ_W-1:0] irq_clr = (apb_access && !pwrite && hit_istat) ?
		prdata[sgps_pkg::IRQ_W-1:0] : '0;

	// supervision state
	sgps_pkg::sgps_state_t st_reg;
	sgps_pkg::sgps_state_t st_next;
	logic dir_close_reg;
	logic fault_reg;
	logic assume_reg;
	logic move_run;
	logic move_exp;
	logic dwell_run;
	logic dwell_exp;

	wire st_idle = st_reg == sgps_pkg::ST_IDLE;
	wire st_move = st_reg == sgps_pkg::ST_MOVE;
	wire st_dwell = st_reg == sgps_pkg::ST_DWELL;
	wire cfg_both = cfg_reg.close_wired && cfg_reg.open_wired;
	wire cfg_one = cfg_reg.close_wired ^ cfg_reg.open_wired;
	// open takes priority; a running command blocks any further one
	wire start_open = cmd_wr && pwdata[sgps_pkg::CMD_OPEN_BIT] && st_idle;
	wire start_close = cmd_wr && pwdata[sgps_pkg::CMD_CLOSE_BIT]
		&& !pwdata[sgps_pkg::CMD_OPEN_BIT] && st_idle;
	wire start_any = start_open || start_close;
	// position as seen by the wired contacts; an unwired one is inferred
	wire closed_ind = cfg_reg.close_wired ? (closed_s && !(cfg_reg.open_wired && open_s)) : !open_s;
	wire open_ind = cfg_reg.open_wired ? (open_s && !(cfg_reg.close_wired && closed_s)) : !closed_s;
	wire reached = dir_close_reg ? closed_ind : open_ind;
	wire supervised = dir_close_reg ? cfg_reg.close_wired : cfg_reg.open_wired;
	wire move_reached = st_move && reached;
	wire move_timeout = st_move && move_exp && !reached;
	wire go_dwell = move_timeout && supervised && cfg_one && cfg_reg.dwell_en;
	wire [CNT_W-1:0] move_limit = dir_close_reg ? ton_reg : toff_reg;

	sgps_timer #(.CNT_W(CNT_W)) u_move (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(start_any),
		.stop(move_reached),
		.limit(move_limit),
		.running(move_run),
		.expired(move_exp)
	);
	sgps_timer #(.CNT_W(CNT_W)) u_dwell (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(go_dwell),
		.stop(start_any),
		.limit(tdwell_reg),
		.running(dwell_run),
		.expired(dwell_exp)
	);

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			sgps_pkg::ST_IDLE: begin
				if (start_any) st_next = sgps_pkg::ST_MOVE;
			end
			sgps_pkg::ST_MOVE: begin
				if (move_reached) st_next = sgps_pkg::ST_IDLE;
				else if (go_dwell) st_next = sgps_pkg::ST_DWELL;
				else if (move_exp) st_next = sgps_pkg::ST_IDLE;
			end
			sgps_pkg::ST_DWELL: begin
				if (dwell_exp) st_next = sgps_pkg::ST_IDLE;
			end
			default: st_next = sgps_pkg::ST_IDLE;
		endcase
	end

	wire indet_now = (st_move && supervised && !reached) || st_dwell;
	// a supervised timeout without dwell latches a fault
	wire fault_set = move_timeout && supervised && !go_dwell;
	wire fault_next = fault_set || (fault_reg && !start_any && !reached);

	// position decode
	sgps_pkg::sgps_pos_t pos_next;
	always_comb begin
		pos_next = sgps_pkg::POS_DIST;
		if (!cfg_reg.close_wired && !cfg_reg.open_wired) begin
			pos_next = sgps_pkg::POS_DIST;
		end else if (fault_reg && !reached) begin
			pos_next = sgps_pkg::POS_DIST;
		end else if (cfg_both) begin
			if (closed_s != open_s) pos_next = closed_s ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
			else pos_next = indet_now ? sgps_pkg::POS_INDET : sgps_pkg::POS_DIST;
		end else if (cfg_reg.close_wired) begin
			if (closed_s) pos_next = sgps_pkg::POS_CLOSED;
			else if (indet_now) pos_next = sgps_pkg::POS_INDET;
			else pos_next = assume_reg ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
		end else begin
			if (open_s) pos_next = sgps_pkg::POS_OPEN;
			else if (indet_now) pos_next = sgps_pkg::POS_INDET;
			else pos_next = assume_reg ? sgps_pkg::POS_OPEN : sgps_pkg::POS_CLOSED;
		end
	end

	// pulse ends on feedback or travel expiry
	wire pulse_on = st_move && !reached && !move_exp;
	wire close_next = start_close || (pulse_on && dir_close_reg);
	wire open_next = start_open || (pulse_on && !dir_close_reg);
	wire success_next = move_reached || (command_success_flag && !start_any);
	wire [sgps_pkg::IRQ_W-1:0] irq_ev = {pos_next != pos_code, fault_set, move_reached};
	// set wins over the read clear
	wire [sgps_pkg::IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_reg <= sgps_pkg::ST_IDLE;
			dir_close_reg <= 1'b0;
			fault_reg <= 1'b0;
			assume_reg <= 1'b0;
			close_cmd <= 1'b0;
			open_cmd <= 1'b0;
			command_success_flag <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (start_any) dir_close_reg <= start_close;
			fault_reg <= fault_next;
			// end position assumed after the dwell
			assume_reg <= (st_dwell && dwell_exp) || (assume_reg && !start_any && !(wr_ok && hit_ctrl));
			close_cmd <= close_next;
			open_cmd <= open_next;
			command_success_flag <= success_next;
		end
	end

	// registered indications
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pos_code <= sgps_pkg::POS_DIST;
			flags <= '{disturbed: 1'b1, default: 1'b0};
			one_contact_flag <= 1'b0;
			irq <= 1'b0;
		end else begin
			pos_code <= pos_next;
			flags.closed <= pos_next == sgps_pkg::POS_CLOSED;
			flags.open <= pos_next == sgps_pkg::POS_OPEN;
			flags.indeterminate <= pos_next == sgps_pkg::POS_INDET;
			flags.disturbed <= pos_next == sgps_pkg::POS_DIST;
			flags.one_contact <= cfg_one;
			one_contact_flag <= cfg_one;
			flags.success <= success_next;
			irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// read mux
	wire [31:0] rd_data = hit_ctrl ? {29'h0, cfg_reg} :
		hit_ton ? 32'(ton_reg) :
		hit_toff ? 32'(toff_reg) :
		hit_tdwell ? 32'(tdwell_reg) :
		hit_status ? {21'h0, open_cmd, close_cmd, !st_idle, flags, pos_code} :
		hit_istat ? {29'h0, irq_stat_reg} :
		hit_imask ? {29'h0, irq_mask_reg} : 32'h0;

	// apb answers in the first cycle of the access phase, with no wait states
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_hit;
			if (apb_setup) prdata <= pwrite ? 32'h0 : rd_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_reg <= sgps_pkg::CTRL_RST;
			ton_reg <= CNT_W'(sgps_pkg::TMOVE_ON_RST);
			toff_reg <= CNT_W'(sgps_pkg::TMOVE_OFF_RST);
			tdwell_reg <= CNT_W'(sgps_pkg::TDWELL_RST);
			irq_mask_reg <= sgps_pkg::IRQ_MASK_RST;
			irq_stat_reg <= '0;
		end else begin
			if (wr_ok && hit_ctrl) cfg_reg <= pwdata[2:0];
			if (wr_ok && hit_ton) ton_reg <= pwdata[CNT_W-1:0];
			if (wr_ok && hit_toff) toff_reg <= pwdata[CNT_W-1:0];
			if (wr_ok && hit_tdwell) tdwell_reg <= pwdata[CNT_W-1:0];
			if (wr_ok && hit_imask) irq_mask_reg <= pwdata[sgps_pkg::IRQ_W-1:0];
			irq_stat_reg <= irq_stat_next;
		end
	end

	// helper: cycles the current command pulse has lasted
	logic [CNT_W:0] pulse_len_reg;
	always_ff @(posedge clk_sys) begin
		if (reset || !(close_next || open_next)) pulse_len_reg <= '0;
		else pulse_len_reg <= pulse_len_reg + (CNT_W+1)'(1);
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	pos_flags_a: assert property (flags.closed == (pos_code == sgps_pkg::POS_CLOSED)
		&& flags.disturbed == (pos_code == sgps_pkg::POS_DIST)) else $error("flags disagree with code");
	close_start_a: assert property (start_close |=> close_cmd && st_move && dir_close_reg
		##1 (!close_cmd || st_move)) else $error("close command did not start travel");
	close_done_a: assert property (st_move && dir_close_reg && cfg_both && reached
		|=> command_success_flag && !close_cmd ##1 pos_code == sgps_pkg::POS_CLOSED)
		else $error("closed feedback not reported");
	timeout_dist_a: assert property (fault_set && cfg_both |=> fault_reg
		##1 (pos_code == sgps_pkg::POS_DIST || reached || $past(start_any)))
		else $error("timeout did not give disturbed");
	open_start_a: assert property (start_open |=> open_cmd && !close_cmd && !dir_close_reg)
		else $error("open command did not start travel");
	two_closed_a: assert property (cfg_both && !fault_reg && closed_s && !open_s
		|=> pos_code == sgps_pkg::POS_CLOSED) else $error("two-contact closed wrong");
	equal_idle_a: assert property (cfg_both && closed_s == open_s && st_idle
		|=> pos_code == sgps_pkg::POS_DIST) else $error("equal contacts not disturbed");
	pulse_len_a: assert property ((close_cmd || open_cmd)
		|-> pulse_len_reg <= (CNT_W+1)'(move_limit) + (CNT_W+1)'(1))
		else $error("command pulse too long");
	one_flag_a: assert property (##1 one_contact_flag == $past(cfg_one))
		else $error("one-contact flag wrong");
	single_ok_a: assert property (cfg_one && move_reached |=> command_success_flag
		&& !flags.indeterminate) else $error("single-contact success wrong");
	none_dist_a: assert property (!cfg_reg.close_wired && !cfg_reg.open_wired
		|=> pos_code == sgps_pkg::POS_DIST) else $error("unassigned contact not disturbed");
	closed_only_a: assert property (cfg_reg.close_wired && !cfg_reg.open_wired && closed_s
		&& !fault_reg |=> pos_code == sgps_pkg::POS_CLOSED) else $error("closed-only wrong");
	dwell_indet_a: assert property (go_dwell |=> st_dwell
		&& (pos_next == sgps_pkg::POS_INDET || reached)) else $error("dwell not indeterminate");

	cov_close_ok: cover property (start_close ##[1:300] move_reached);
	cov_timeout: cover property (st_move ##1 fault_reg);
	cov_dwell: cover property (st_dwell ##1 st_idle ##1 assume_reg);
	cov_irq: cover property (irq ##1 apb_access && hit_istat);
endmodule : sgps_supervisor
`default_nettype wire

// ### sgps_pkg.sv
// shared constants and types of the switchgear position supervisor
package sgps_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_TMOVE_ON = 8'h08;
	localparam logic [7:0] ADDR_TMOVE_OFF = 8'h0c;
	localparam logic [7:0] ADDR_TDWELL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

	localparam int CTRL_CLOSE_WIRED_BIT = 0;
	localparam int CTRL_OPEN_WIRED_BIT = 1;
	localparam int CTRL_DWELL_EN_BIT = 2;
	localparam int CMD_CLOSE_BIT = 0;
	localparam int CMD_OPEN_BIT = 1;
	localparam int IRQ_W = 3;
	localparam int IRQ_SUCCESS_BIT = 0;
	localparam int IRQ_TIMEOUT_BIT = 1;
	localparam int IRQ_POS_CHANGE_BIT = 2;

	localparam logic [2:0] CTRL_RST = 3'h3;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam int TMOVE_ON_RST = 1000;
	localparam int TMOVE_OFF_RST = 1000;
	localparam int TDWELL_RST = 500;

	typedef enum logic [1:0] {
		POS_INDET = 2'h0,
		POS_OPEN = 2'h1,
		POS_CLOSED = 2'h2,
		POS_DIST = 2'h3
	} sgps_pos_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MOVE = 3'b010,
		ST_DWELL = 3'b100
	} sgps_state_t;

	typedef struct packed {
		logic dwell_en;
		logic open_wired;
		logic close_wired;
	} sgps_cfg_t;

	typedef struct packed {
		logic success;
		logic one_contact;
		logic disturbed;
		logic indeterminate;
		logic open;
		logic closed;
	} sgps_flags_t;
endpackage : sgps_pkg

// ### sgps_timer.sv
// travel or dwell timer counting clock ticks to a terminal count
`timescale 1ns/1ps
`default_nettype none
module sgps_timer #(
	parameter int CNT_W = 24
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start,
	input wire logic stop,
	input wire logic [CNT_W-1:0] limit,
	output logic running,
	output logic expired
);
	logic [CNT_W-1:0] cnt_reg;
	logic run_reg;
	logic [CNT_W-1:0] cnt_inc;

	initial begin
		if (CNT_W < 2 || CNT_W > 32) $error("sgps_timer: CNT_W out of range");
	end

	assign cnt_inc = cnt_reg + CNT_W'(1);
	// a zero limit behaves as one tick
	assign expired = run_reg && (cnt_inc >= limit);
	assign running = run_reg;

	always_ff @(posedge clk_sys) begin
		if (reset || start) begin
			cnt_reg <= '0;
		end else if (run_reg) begin
			cnt_reg <= cnt_inc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			run_reg <= 1'b0;
		end else if (start) begin
			run_reg <= 1'b1;
		end else if (stop || expired) begin
			run_reg <= 1'b0;
		end
	end
endmodule : sgps_timer
`default_nettype wire

// ### sgps_gear_model.sv
// behavioural switchgear with two auxiliary contacts and command relays
`timescale 1ns/1ps
`default_nettype none
module sgps_gear_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic close_cmd,
	input wire logic open_cmd,
	input wire logic [7:0] move_dly,
	input wire logic stuck,
	output logic aux_closed_pin,
	output logic aux_open_pin
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aux_closed_pin <= 1'b0;
			aux_open_pin <= 1'b1;
			cnt_reg <= 8'h0;
		end else if (close_cmd || open_cmd) begin
			cnt_reg <= cnt_reg + 8'h1;
			// contacts part at once, so travel shows both low; a gear at its target stays put
			if (cnt_reg == 8'h0 && !(close_cmd ? aux_closed_pin : aux_open_pin)) begin
				aux_closed_pin <= 1'b0;
				aux_open_pin <= 1'b0;
			end
			// a stuck gear never reaches its end position
			if (!stuck && cnt_reg == move_dly) begin
				aux_closed_pin <= close_cmd;
				aux_open_pin <= open_cmd;
			end
		end else begin
			cnt_reg <= 8'h0;
		end
	end
endmodule : sgps_gear_model
`default_nettype wire

// ### switchgear_position_supervisor_tb.sv
// self-checking bench of the switchgear position supervisor
`timescale 1ns/1ps
`default_nettype none
module switchgear_position_supervisor_tb;
	logic clk_sys;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic stuck = 1'b0;
	logic [7:0] move_dly = 8'h4;
	logic pready, pslverr, aux_closed_pin, aux_open_pin, close_cmd, open_cmd;
	logic one_contact_flag, command_success_flag, irq, d;
	logic [31:0] prdata;
	logic [1:0] pos_code;
	sgps_pkg::sgps_flags_t flags;
	logic [64:0] notes[$];
	logic [64:0] nt;
	int err_count, checks_done, len, last_len, n, i;

	sgps_supervisor #(.CNT_W(24)) sgps_supervisor_i (.clk_sys(clk_sys), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_closed_pin(aux_closed_pin),
		.aux_open_pin(aux_open_pin), .close_cmd(close_cmd), .open_cmd(open_cmd),
		.pos_code(pos_code), .flags(flags), .one_contact_flag(one_contact_flag),
		.command_success_flag(command_success_flag), .irq(irq));
	sgps_gear_model sgps_gear_model_i (.clk_sys(clk_sys), .reset(reset),
		.close_cmd(close_cmd), .open_cmd(open_cmd), .move_dly(move_dly), .stuck(stuck),
		.aux_closed_pin(aux_closed_pin), .aux_open_pin(aux_open_pin));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// oldest note against each finished transfer
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check({pslverr, prdata & nt[63:32]}, {nt[64], nt[31:0] & nt[63:32]});
		end
	end

	// length of the last command pulse in cycles
	always @(posedge clk_sys) begin
		if (close_cmd === 1'b1 || open_cmd === 1'b1) begin
			len <= len + 1;
		end else if (len != 0) begin
			last_len <= len;
			len <= 0;
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat,
			input logic [64:0] note);
		@(posedge clk_sys);
		notes.push_back(note);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no wait count here: only the watchdog ends a hung transfer
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		apb(1'b1, a, dat, {1'b0, 64'h0});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, m, e});
	endtask : rd

	// contacts part, pass the filter, then the indeterminate code lands
	task automatic cmd(input logic [31:0] c);
		wr(sgps_pkg::ADDR_CMD, c);
		repeat (7) @(posedge clk_sys);
	endtask : cmd

	task automatic wait_pos(input logic [1:0] p, input int lim);
		n = 0;
		while (pos_code !== p && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		check({31'h0, pos_code}, {31'h0, p});
	endtask : wait_pos

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		results();
	end

	initial begin
		void'($urandom(32'hf49fd5fd));
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(sgps_pkg::ADDR_CTRL, 32'h7, 32'h3);
		rd(sgps_pkg::ADDR_TMOVE_ON, 32'hffffff, 32'h3e8);
		rd(sgps_pkg::ADDR_TDWELL, 32'hffffff, 32'h1f4);
		rd(sgps_pkg::ADDR_IRQ_MASK, 32'h7, 32'h0);
		rd(sgps_pkg::ADDR_STATUS, 32'h7ff, 32'h9);
		apb(1'b0, 8'h20, 32'h0, {1'b1, 32'hffffffff, 32'h0});
		apb(1'b1, 8'h24, 32'h5, {1'b1, 64'h0});
		check({32'h0, one_contact_flag}, 33'h0);
		wr(sgps_pkg::ADDR_TMOVE_ON, 32'h14);
		wr(sgps_pkg::ADDR_TMOVE_OFF, 32'h14);
		wr(sgps_pkg::ADDR_IRQ_MASK, 32'h7);
		move_dly <= 8'h6;
		cmd(32'h1);
		rd(sgps_pkg::ADDR_STATUS, 32'h7ff, 32'h310);
		wait_pos(2'h2, 40);
		repeat (2) @(posedge clk_sys);
		check({32'h0, last_len > 0 && last_len < 20}, 33'h1);
		rd(sgps_pkg::ADDR_STATUS, 32'h7ff, 32'h86);
		check({32'h0, irq}, 33'h1);
		rd(sgps_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
		// open that never arrives, a close meanwhile is refused
		stuck <= 1'b1;
		cmd(32'h2);
		wr(sgps_pkg::ADDR_CMD, 32'h1);
		rd(sgps_pkg::ADDR_STATUS, 32'h7ff, 32'h510);
		wait_pos(2'h3, 40);
		repeat (3) @(posedge clk_sys);
		check({1'b0, last_len}, 33'h14);
		rd(sgps_pkg::ADDR_STATUS, 32'h7ff, 32'h23);
		rd(sgps_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
		stuck <= 1'b0;
		wr(sgps_pkg::ADDR_IRQ_MASK, 32'h0);
		for (i = 0; i < 4; i++) begin
			d = 1'($urandom_range(1));
			move_dly <= 8'($urandom_range(10, 1));
			cmd(d ? 32'h1 : 32'h2);
			wait_pos(d ? 2'h2 : 2'h1, 40);
			rd(sgps_pkg::ADDR_STATUS, 32'h7ff, d ? 32'h86 : 32'h89);
		end
		check({32'h0, irq}, 33'h0);
		wr(sgps_pkg::ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		check({32'h0, irq}, 33'h1);
		rd(sgps_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
		repeat (3) @(posedge clk_sys);
		check({32'h0, irq}, 33'h0);
		move_dly <= 8'h3;
		cmd(32'h2);
		wait_pos(2'h1, 40);
		// closed contact only, with dwell after a stuck close
		wr(sgps_pkg::ADDR_TDWELL, 32'ha);
		wr(sgps_pkg::ADDR_CTRL, 32'h5);
		repeat (3) @(posedge clk_sys);
		check({31'h0, pos_code}, 33'h1);
		check({32'h0, one_contact_flag}, 33'h1);
		stuck <= 1'b1;
		cmd(32'h1);
		check({31'h0, pos_code}, 33'h0);
		wait_pos(2'h2, 60);
		check({32'h0, n > 24 && n < 40}, 33'h1);
		// open contact only
		wr(sgps_pkg::ADDR_CTRL, 32'h2);
		stuck <= 1'b0;
		cmd(32'h2);
		wait_pos(2'h1, 40);
		check({32'h0, command_success_flag}, 33'h1);
		check({32'h0, flags.one_contact}, 33'h1);
		cmd(32'h1);
		check({32'h0, pos_code != 2'h0}, 33'h1);
		wait_pos(2'h2, 40);
		wr(sgps_pkg::ADDR_CTRL, 32'h0);
		repeat (4) @(posedge clk_sys);
		check({31'h0, pos_code}, 33'h3);
		results();
	end
endmodule : switchgear_position_supervisor_tb
`default_nettype wire
